// ===== core/rwc_cfg.svh
// Constants of the reset and supervisory timer block
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH
`define RWC_ADDR_W 12
`define RWC_ADDR_CAUSE 12'h000
`define RWC_ADDR_TCTRL 12'h004
`define RWC_ADDR_RESTART 12'h008
`define RWC_CF_TIMER 3
`define RWC_CF_UV 2
`define RWC_CF_PIN 1
`define RWC_CF_SUPPLY 0
`define RWC_CF_W 4
`define RWC_CAUSE_POR 4'h1
`define RWC_TC_IRQF 7
`define RWC_TC_IRQE 6
`define RWC_TC_TS3 5
`define RWC_TC_UNLK 4
`define RWC_TC_EN 3
`define RWC_TC_TSHI 2
`define RWC_TS_W 4
`define RWC_CLK_NS 5
`define RWC_PIN_MIN_NS 2500
`define RWC_PIN_MIN_CYC \
  ((`RWC_PIN_MIN_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS)
`define RWC_UNLOCK_CYC 4
`define RWC_TO_BASE 2048
`define RWC_TO_MAX_SEL 9
`define RWC_TO_W 21
`define RWC_DLY_BASE_CYC 64
`define RWC_DLY_W 24
`endif

// ===== core/rwc_pkg.sv
// Types of the reset and supervisory timer block
`include "rwc_cfg.svh"
package rwc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`RWC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } rwc_apb_req_s;

  typedef enum logic [1:0] {
    RST_HOLD = 2'b00,
    RST_STRETCH = 2'b01,
    RST_RUN = 2'b11,
    RST_WPULSE = 2'b10
  } rwc_rst_state_e;
endpackage

// ===== core/rwc_top.sv
// Reset merge, start-up stretch, cause flags and supervisory timer
//
// How it works
// - Internal reset returns control registers to initial values
// - Any active source forces reset state at once
// - Stretch reset by fuse-selected delay after release
// - Four causes: supply, pin, undervoltage, timer
// - Supply low resets immediately, rise starts delay
// - Long pin low resets, rise starts delay
// - Disable fuse makes reset pin ignored
// - Enabled undervoltage detector resets, recovery starts delay
// - Timer expiry gives one-cycle pulse, then delay
// - Timer, undervoltage, pin flags: set by cause
// - Supply flag cleared only by writing zero
// - Upper four cause bits read zero
// - Timer counts its own slow oscillator cycles
// - Expiry at selected count; restart clears count
// - Interrupt mode raises interrupt, usable for wake
// - Reset mode causes system reset at expiry
// - Combined mode: interrupt first, then reset
// - Always-on fuse forces reset mode
// - Unlock write needs unlock and enable together
// - Protected change only within four cycles
// - Time-out selectable from 16ms to 8s
// - Unlock bit self-clears after four cycles
// - Enable reads one while timer flag set
// - Time-out is 2048 cycles times two per code
// - Interrupt flag cleared by vector or writing one
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rwc_cfg.svh"

module rwc_top #(
  parameter int unsigned DLY_BASE = `RWC_DLY_BASE_CYC,
  parameter int unsigned PIN_MIN = `RWC_PIN_MIN_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire rwc_pkg::rwc_apb_req_s apb_in,
  output logic [31:0] apb_prdata_out,
  output logic apb_pready_out,
  output logic apb_pslverr_out,
  input wire logic supply_low_in,
  input wire logic rst_pin_n_in,
  input wire logic pin_reset_disable_fuse_in,
  input wire logic uv_enable_fuse_in,
  input wire logic uv_below_in,
  input wire logic always_on_fuse_in,
  input wire logic [1:0] startup_time_fuse_in,
  input wire logic [1:0] clock_select_fuse_in,
  input wire logic wdt_osc_in,
  input wire logic irq_ack_in,
  output logic internal_reset_out,
  output logic timeout_irq_out
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  localparam int PIN_W = $clog2(PIN_MIN + 1);
  localparam logic [`RWC_DLY_W-1:0] DLY_BASE_V =
    `RWC_DLY_W'(DLY_BASE);
  localparam logic [`RWC_TO_W-1:0] TO_BASE_V =
    `RWC_TO_W'(`RWC_TO_BASE);
  localparam logic [`RWC_TS_W-1:0] TO_MAX_V =
    `RWC_TS_W'(`RWC_TO_MAX_SEL);
  localparam logic [2:0] UNLK_V = 3'(`RWC_UNLOCK_CYC);

  rwc_pkg::rwc_rst_state_e st_q;
  rwc_pkg::rwc_rst_state_e st_d;
  logic [`RWC_DLY_W-1:0] dly_q;
  logic [`RWC_DLY_W-1:0] dly_len;
  logic [PIN_W-1:0] pin_cnt_q;
  logic pin_rst_q;
  logic [`RWC_CF_W-1:0] cause_q;
  logic [`RWC_CF_W-1:0] cause_d;
  logic irqf_q;
  logic irqe_q;
  logic en_q;
  logic [`RWC_TS_W-1:0] tsel_q;
  logic [`RWC_TS_W-1:0] tsel_c;
  logic [2:0] unlk_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic [`RWC_TO_W-1:0] wcnt_q;
  logic [`RWC_TO_W-1:0] to_lim;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic rst_out_q;
  logic irq_out_q;

  logic uv_src;
  logic src_any;
  logic apb_acc;
  logic wr_fire;
  logic wr_cause;
  logic wr_tc;
  logic wr_restart;
  logic [7:0] wd;
  logic en_eff;
  logic ie_eff;
  logic tick;
  logic running;
  logic expire;
  logic exp_rst;
  logic exp_irq;
  logic in_run;
  logic unlk_open;

  // ----------------------------------------------------------
  // Source merge and decode
  // ----------------------------------------------------------
  assign uv_src = uv_enable_fuse_in & uv_below_in;
  assign src_any = supply_low_in | pin_rst_q | uv_src;
  assign apb_acc = apb_in.psel & apb_in.penable;
  assign wr_fire = apb_acc & apb_in.pwrite & pready_q;
  assign wr_cause = wr_fire & (apb_in.paddr == `RWC_ADDR_CAUSE);
  assign wr_tc = wr_fire & (apb_in.paddr == `RWC_ADDR_TCTRL);
  assign wr_restart = wr_fire &
    (apb_in.paddr == `RWC_ADDR_RESTART);
  assign wd = apb_in.pwdata[7:0];
  assign in_run = (st_q == rwc_pkg::RST_RUN);
  assign unlk_open = (unlk_q != 3'h0);

  // Enable held by timer flag and fuse
  assign en_eff = en_q | cause_q[`RWC_CF_TIMER] |
    always_on_fuse_in;
  assign ie_eff = irqe_q & ~always_on_fuse_in;

  // ----------------------------------------------------------
  // Oscillator synchroniser and tick
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else if (ce_in) begin
      osc_s1_q <= wdt_osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign tick = osc_s2_q & ~osc_s3_q;

  // ----------------------------------------------------------
  // Supervisory timer count and expiry
  // ----------------------------------------------------------
  assign tsel_c = (tsel_q > TO_MAX_V) ? TO_MAX_V : tsel_q;
  assign to_lim = TO_BASE_V << tsel_c;
  assign running = (en_eff | ie_eff) & in_run;
  assign expire = running & tick &
    (wcnt_q == to_lim - `RWC_TO_W'(1));
  // Combined mode resets once the flag is still pending
  assign exp_rst = expire & en_eff & (~ie_eff | irqf_q);
  assign exp_irq = expire & ie_eff & ~exp_rst;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wcnt_q <= '0;
    end else if (ce_in) begin
      if (!running || wr_restart) begin
        wcnt_q <= '0;
      end else if (expire) begin
        wcnt_q <= '0;
      end else if (tick) begin
        wcnt_q <= wcnt_q + `RWC_TO_W'(1);
      end
    end
  end

  // ----------------------------------------------------------
  // Reset pin filter
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pin_cnt_q <= '0;
      pin_rst_q <= 1'b0;
    end else if (ce_in) begin
      if (rst_pin_n_in || pin_reset_disable_fuse_in) begin
        pin_cnt_q <= '0;
        pin_rst_q <= 1'b0;
      end else begin
        if (pin_cnt_q != PIN_W'(PIN_MIN - 1)) begin
          pin_cnt_q <= pin_cnt_q + PIN_W'(1);
        end else begin
          pin_rst_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------
  assign dly_len = DLY_BASE_V <<
    {clock_select_fuse_in, startup_time_fuse_in};

  always_comb begin
    st_d = st_q;
    case (st_q)
      rwc_pkg::RST_HOLD: begin
        if (!src_any) begin
          st_d = rwc_pkg::RST_STRETCH;
        end
      end
      rwc_pkg::RST_STRETCH: begin
        if (src_any) begin
          st_d = rwc_pkg::RST_HOLD;
        end else if (dly_q == dly_len - `RWC_DLY_W'(1)) begin
          st_d = rwc_pkg::RST_RUN;
        end
      end
      rwc_pkg::RST_RUN: begin
        if (src_any) begin
          st_d = rwc_pkg::RST_HOLD;
        end else if (exp_rst) begin
          st_d = rwc_pkg::RST_WPULSE;
        end
      end
      rwc_pkg::RST_WPULSE: begin
        if (src_any) begin
          st_d = rwc_pkg::RST_HOLD;
        end else begin
          st_d = rwc_pkg::RST_STRETCH;
        end
      end
      default: begin
        st_d = rwc_pkg::RST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_q <= rwc_pkg::RST_HOLD;
      rst_out_q <= 1'b1;
    end else if (ce_in) begin
      st_q <= st_d;
      rst_out_q <= (st_d != rwc_pkg::RST_RUN);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dly_q <= '0;
    end else if (ce_in) begin
      if (st_q == rwc_pkg::RST_STRETCH) begin
        dly_q <= dly_q + `RWC_DLY_W'(1);
      end else begin
        dly_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------
  // Reset cause flags
  // ----------------------------------------------------------
  always_comb begin
    cause_d = cause_q;
    if (wr_cause) begin
      cause_d = cause_q & apb_in.pwdata[`RWC_CF_W-1:0];
    end
    // Causes win over a clearing write
    if (pin_rst_q) begin
      cause_d[`RWC_CF_PIN] = 1'b1;
    end
    if (uv_src) begin
      cause_d[`RWC_CF_UV] = 1'b1;
    end
    if (exp_rst) begin
      cause_d[`RWC_CF_TIMER] = 1'b1;
    end
    if (supply_low_in) begin
      cause_d = `RWC_CAUSE_POR;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cause_q <= `RWC_CAUSE_POR;
    end else if (ce_in) begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------
  // Timer control and timed unlock
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      en_q <= 1'b0;
      tsel_q <= '0;
      unlk_q <= 3'h0;
    end else if (ce_in) begin
      if (!in_run) begin
        en_q <= 1'b0;
        tsel_q <= '0;
        unlk_q <= 3'h0;
      end else if (wr_tc && wd[`RWC_TC_UNLK] && wd[`RWC_TC_EN]) begin
        en_q <= 1'b1;
        unlk_q <= UNLK_V;
      end else if (wr_tc && unlk_open && !wd[`RWC_TC_UNLK]) begin
        en_q <= wd[`RWC_TC_EN] | cause_q[`RWC_CF_TIMER];
        tsel_q <= {wd[`RWC_TC_TS3],
          wd[`RWC_TC_TSHI:0]};
        unlk_q <= 3'h0;
      end else begin
        if (wr_tc && wd[`RWC_TC_EN]) begin
          en_q <= 1'b1;
        end
        if (unlk_open) begin
          unlk_q <= unlk_q - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irqe_q <= 1'b0;
    end else if (ce_in) begin
      if (!in_run) begin
        irqe_q <= 1'b0;
      end else if (irq_ack_in && en_eff) begin
        irqe_q <= 1'b0;
      end else if (wr_tc) begin
        irqe_q <= wd[`RWC_TC_IRQE];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irqf_q <= 1'b0;
    end else if (ce_in) begin
      if (!in_run) begin
        irqf_q <= 1'b0;
      end else if (exp_irq) begin
        irqf_q <= 1'b1;
      end else if (irq_ack_in ||
                   (wr_tc && wd[`RWC_TC_IRQF])) begin
        irqf_q <= 1'b0;
      end
    end
  end

  // Wake source: registered on the system clock from flag and interrupt enable
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irq_out_q <= 1'b0;
    end else if (ce_in) begin
      irq_out_q <= irqf_q & ie_eff;
    end
  end

  // ----------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce_in) begin
      if (apb_acc && !pready_q) begin
        pready_q <= 1'b1;
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0;
        case (apb_in.paddr)
          `RWC_ADDR_CAUSE: begin
            prdata_q[`RWC_CF_W-1:0] <= cause_q;
          end
          `RWC_ADDR_TCTRL: begin
            prdata_q[7:0] <= {irqf_q, ie_eff, tsel_q[3],
              unlk_open, en_eff, tsel_q[2:0]};
          end
          `RWC_ADDR_RESTART: begin
            prdata_q <= 32'h0;
          end
          default: begin
            pslverr_q <= 1'b1;
          end
        endcase
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign apb_prdata_out = prdata_q;
  assign apb_pready_out = pready_q;
  assign apb_pslverr_out = pslverr_q;
  assign internal_reset_out = rst_out_q;
  assign timeout_irq_out = irq_out_q;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  supply_hold_a: assert property (
    ce_in && supply_low_in |=> internal_reset_out &&
      st_q == rwc_pkg::RST_HOLD)
    else $error("supply low did not hold reset");

  pin_off_a: assert property (
    ce_in && pin_reset_disable_fuse_in |=> !pin_rst_q)
    else $error("pin reset active while disabled");

  stretch_a: assert property (
    ce_in && st_q == rwc_pkg::RST_STRETCH && !src_any &&
      dly_q != dly_len - `RWC_DLY_W'(1)
    |=> st_q == rwc_pkg::RST_STRETCH && internal_reset_out)
    else $error("reset released before delay end");

  wpulse_once_a: assert property (
    ce_in && st_q == rwc_pkg::RST_WPULSE
    |=> st_q != rwc_pkg::RST_WPULSE && internal_reset_out)
    else $error("timer reset pulse not one cycle");

  cause_hi_a: assert property (
    pready_q && apb_in.paddr == `RWC_ADDR_CAUSE
    |-> prdata_q[31:`RWC_CF_W] == '0 &&
      prdata_q[`RWC_CF_W-1:0] == $past(cause_q))
    else $error("unused cause bits not zero");

  supply_flag_a: assert property (
    ce_in && supply_low_in |=> cause_q == `RWC_CAUSE_POR)
    else $error("supply flag state wrong");

  timer_flag_a: assert property (
    ce_in && exp_rst && !supply_low_in
    |=> cause_q[`RWC_CF_TIMER] && en_eff)
    else $error("timer flag not set on expiry");

  unlock_a: assert property (
    ce_in && unlk_q == 3'h1 && !wr_tc |=> unlk_q == 3'h0)
    else $error("unlock window not closed");

  fuse_a: assert property (
    ce_in && always_on_fuse_in && expire && !src_any
    |=> st_q == rwc_pkg::RST_WPULSE)
    else $error("always-on expiry did not reset");

  guard_a: assert property (
    ce_in && wr_tc && !unlk_open && in_run
    |=> tsel_q == $past(tsel_q))
    else $error("time-out changed outside window");

  irq_flag_a: assert property (
    ce_in && exp_irq && st_d == rwc_pkg::RST_RUN |=> irqf_q)
    else $error("interrupt flag not set on expiry");

  timer_rst_c: cover property (st_q == rwc_pkg::RST_WPULSE);
  timer_irq_c: cover property (exp_irq);
  release_c: cover property (
    st_q == rwc_pkg::RST_STRETCH ##1 st_q == rwc_pkg::RST_RUN);
  pin_rst_c: cover property (pin_rst_q);

endmodule

`default_nettype wire

// ===== verification/rwc_core_model.sv
// Processor core model: register accesses, restart and vector taking
`timescale 1ns/1ps
`default_nettype none
`include "rwc_cfg.svh"
module rwc_core_model (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output var rwc_pkg::rwc_apb_req_s apb_out,
  output var logic irq_ack_out
);
  initial begin
    apb_out = '0;
    irq_ack_out = 1'h0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input bit b2b, output logic [31:0] r,
      output logic e);
    if (!b2b) @(posedge clk_in);
    apb_out.psel <= 1'h1;
    apb_out.penable <= 1'h0;
    apb_out.pwrite <= w;
    apb_out.paddr <= a;
    apb_out.pwdata <= d;
    @(posedge clk_in);
    apb_out.penable <= 1'h1;
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'h1);
    r = prdata_in;
    e = pslverr_in;
  endtask
  // Released data lines show the inverse of the last value
  task automatic idle();
    apb_out.psel <= 1'h0;
    apb_out.penable <= 1'h0;
    apb_out.pwdata <= ~apb_out.pwdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'h1, a, d, 1'h0, r, e);
    idle();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r,
      output logic e);
    xfer(1'h0, a, 32'h0, 1'h0, r, e);
    idle();
  endtask
  task automatic unlock(input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'h1, `RWC_ADDR_TCTRL, d | 32'h18, 1'h0, r, e);
    xfer(1'h1, `RWC_ADDR_TCTRL, d, 1'h1, r, e);
    idle();
  endtask
  task automatic restart();
    wr(`RWC_ADDR_RESTART, 32'h0);
  endtask
  task automatic take_cause(output logic [31:0] r);
    logic e;
    rd(`RWC_ADDR_CAUSE, r, e);
    wr(`RWC_ADDR_CAUSE, 32'h0);
  endtask
  task automatic ack();
    @(posedge clk_in);
    irq_ack_out <= 1'h1;
    @(posedge clk_in);
    irq_ack_out <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== verification/rwc_top_tb.sv
// Self-checking bench for the reset and supervisory timer block
`timescale 1ns/1ps
`default_nettype none
`include "rwc_cfg.svh"
module rwc_top_tb;
  localparam int DB = 2;
  localparam int PM = 4;
  localparam logic [11:0] CA = `RWC_ADDR_CAUSE;
  localparam logic [11:0] TC = `RWC_ADDR_TCTRL;
  logic clk_sys_in, rst_n_in, sup_low, pin_n, pin_dis, uv_en, uv_below;
  logic aon, pready, pslverr, irst, irq, ack, rd_err, ce;
  logic [1:0] st_fuse, cs_fuse;
  logic [1:0] osc_cnt = 2'h0;
  logic [31:0] prdata, rd_val;
  rwc_pkg::rwc_apb_req_s apb;
  int failures, checks_done, c;
  int cyc = 0;
  rwc_core_model core (.clk_in(clk_sys_in), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr), .apb_out(apb),
    .irq_ack_out(ack));
  rwc_top #(.DLY_BASE(DB), .PIN_MIN(PM)) dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .ce_in(ce), .apb_in(apb),
    .apb_prdata_out(prdata), .apb_pready_out(pready),
    .apb_pslverr_out(pslverr), .supply_low_in(sup_low),
    .rst_pin_n_in(pin_n), .pin_reset_disable_fuse_in(pin_dis),
    .uv_enable_fuse_in(uv_en), .uv_below_in(uv_below),
    .always_on_fuse_in(aon), .startup_time_fuse_in(st_fuse),
    .clock_select_fuse_in(cs_fuse), .wdt_osc_in(osc_cnt[1]),
    .irq_ack_in(ack), .internal_reset_out(irst),
    .timeout_irq_out(irq));
  initial begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // Slow oscillator at a quarter of the system clock
  always @(posedge clk_sys_in) begin
    osc_cnt <= osc_cnt + 2'h1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      conclude();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    checks_done++;
    if (g < lo || g > hi) begin
      failures++;
      $display("BAD %0t count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    core.rd(a, rd_val, rd_err);
    chk(rd_val, e);
  endtask
  task automatic wait_for(input bit on_irq, input logic v, input int n);
    c = 0;
    while ((on_irq ? irq : irst) !== v && c < n) begin
      @(negedge clk_sys_in);
      c++;
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    @(negedge clk_sys_in);
    chk(irst, 1'h1);
    rd(CA, 32'h01);
    wait_for(1'h0, 1'h0, 500);
    rd(TC, 32'h00);
    core.rd(12'h00C, rd_val, rd_err);
    chk(rd_err, 1'h1);
    chk(rd_val, 32'h0);
    core.wr(CA, 32'hFF);
    rd(CA, 32'h01);
    core.wr(CA, 32'h0);
    rd(CA, 32'h00);
  endtask
  task automatic t_pin();
    @(posedge clk_sys_in);
    pin_n <= 1'h0;
    repeat (PM + 3) @(negedge clk_sys_in);
    chk(irst, 1'h1);
    @(posedge clk_sys_in);
    pin_n <= 1'h1;
    wait_for(1'h0, 1'h0, 200);
    core.take_cause(rd_val);
    chk(rd_val, 32'h02);
    @(posedge clk_sys_in);
    pin_dis <= 1'h1;
    pin_n <= 1'h0;
    repeat (PM + 4) @(negedge clk_sys_in);
    chk(irst, 1'h0);
    @(posedge clk_sys_in);
    pin_dis <= 1'h0;
    pin_n <= 1'h1;
  endtask
  // Frozen block ignores a long pin low
  task automatic t_freeze();
    @(posedge clk_sys_in);
    ce <= 1'h0;
    pin_n <= 1'h0;
    repeat (PM + 4) @(negedge clk_sys_in);
    chk(irst, 1'h0);
    @(posedge clk_sys_in);
    ce <= 1'h1;
    pin_n <= 1'h1;
  endtask
  task automatic t_uv();
    int dly;
    @(posedge clk_sys_in);
    uv_below <= 1'h1;
    repeat (5) @(negedge clk_sys_in);
    chk(irst, 1'h0);
    for (int i = 0; i < 2; i++) begin
      dly = DB << (i ? 4 : 1);
      @(posedge clk_sys_in);
      {cs_fuse, st_fuse} <= i ? 4'h4 : 4'h1;
      uv_en <= 1'h1;
      uv_below <= 1'h1;
      repeat (3) @(negedge clk_sys_in);
      chk(irst, 1'h1);
      @(posedge clk_sys_in);
      uv_below <= 1'h0;
      wait_for(1'h0, 1'h0, 200);
      chk_rng(c, dly, dly + 6);
      core.take_cause(rd_val);
      chk(rd_val, 32'h04);
    end
    @(posedge clk_sys_in);
    {cs_fuse, st_fuse} <= 4'h0;
    uv_en <= 1'h0;
  endtask
  task automatic t_sup();
    @(posedge clk_sys_in);
    pin_n <= 1'h0;
    repeat (PM + 3) @(negedge clk_sys_in);
    @(posedge clk_sys_in);
    pin_n <= 1'h1;
    sup_low <= 1'h1;
    repeat (3) @(negedge clk_sys_in);
    chk(irst, 1'h1);
    rd(CA, 32'h01);
    @(posedge clk_sys_in);
    sup_low <= 1'h0;
    wait_for(1'h0, 1'h0, 200);
    core.take_cause(rd_val);
    chk(rd_val, 32'h01);
  endtask
  task automatic t_irq();
    core.restart();
    core.wr(TC, 32'h40);
    repeat (6000) @(negedge clk_sys_in);
    chk(irq, 1'h0);
    core.restart();
    repeat (6000) @(negedge clk_sys_in);
    chk(irq, 1'h0);
    wait_for(1'h1, 1'h1, 3000);
    chk(irq, 1'h1);
    chk(irst, 1'h0);
    rd(TC, 32'hC0);
    core.wr(TC, 32'hC0);
    rd(TC, 32'h40);
  endtask
  task automatic t_comb();
    core.wr(TC, 32'h48);
    core.restart();
    wait_for(1'h1, 1'h1, 9000);
    chk(irq, 1'h1);
    chk(irst, 1'h0);
    core.ack();
    rd(TC, 32'h08);
    wait_for(1'h0, 1'h1, 9000);
    chk(irst, 1'h1);
    wait_for(1'h0, 1'h0, 200);
    rd(CA, 32'h08);
    rd(TC, 32'h08);
    core.unlock(32'h0);
    rd(TC, 32'h08);
    core.wr(CA, 32'h0);
    core.unlock(32'h01);
    rd(TC, 32'h01);
    core.wr(TC, 32'h02);
    rd(TC, 32'h01);
    core.wr(TC, 32'h19);
    repeat (8) @(negedge clk_sys_in);
    rd(TC, 32'h09);
    core.unlock(32'h27);
    rd(TC, 32'h27);
    core.unlock(32'h01);
    rd(TC, 32'h01);
  endtask
  task automatic t_aon();
    @(posedge clk_sys_in);
    aon <= 1'h1;
    core.wr(TC, 32'h40);
    rd(TC, 32'h09);
    core.unlock(32'h0);
    rd(TC, 32'h08);
    wait_for(1'h0, 1'h1, 9000);
    chk(irst, 1'h1);
    wait_for(1'h0, 1'h0, 200);
    rd(CA, 32'h08);
  endtask
  initial begin
    {rst_n_in, sup_low, pin_dis, uv_en, uv_below, aon} = 6'h0;
    pin_n = 1'h1;
    {st_fuse, cs_fuse} = 4'h0;
    ce = 1'h1;
    {failures, checks_done} = '0;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    t_regs();
    t_pin();
    t_freeze();
    t_uv();
    t_sup();
    t_irq();
    t_comb();
    t_aon();
    conclude();
  end
endmodule
`default_nettype wire
